// *** rtl/anps_pkg.sv ***
// Constants for the partner next-page ability and expansion registers.
// Assumes a management front end that presents a 5-bit register address.
package anps_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [4:0]  PARTNER_ABILITY_ADDR   = 5'h05;
  localparam logic [4:0]  EXPANSION_ADDR         = 5'h06;

  // ---------------------------------------------------------------
  // Partner ability register, next-page view
  // ---------------------------------------------------------------
  localparam int          PA_MORE_PAGES_BIT      = 15;
  localparam int          PA_ACK_BIT             = 14;
  localparam int          PA_PAGE_TYPE_BIT       = 13;
  localparam int          PA_COMPLY_BIT          = 12;
  localparam int          PA_TOGGLE_BIT          = 11;
  localparam int          PA_CODE_MSB            = 10;
  localparam logic [10:0] PA_CODE_RESET          = 11'h000;
  localparam logic [15:0] PA_RESET               = 16'h0000;

  // ---------------------------------------------------------------
  // Expansion register
  // ---------------------------------------------------------------
  localparam int          EX_FAULT_BIT           = 4;
  localparam int          EX_PARTNER_PAGES_BIT   = 3;
  localparam int          EX_LOCAL_PAGES_BIT     = 2;
  localparam int          EX_PAGE_RX_BIT         = 1;
  localparam int          EX_PARTNER_AN_BIT      = 0;
  localparam logic        EX_LOCAL_PAGES_RESET   = 1'b1;
  localparam logic [15:0] EX_RESERVED_MASK       = 16'hFFE0;

endpackage : anps_pkg

// *** rtl/page_word_hold.sv ***
// Holds the received next-page link code word for the partner register.
// Assumes a one-cycle load strobe from the arbitration logic.
`timescale 1ns/1ps
module page_word_hold (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        load,
  input  wire logic [15:0] word_in,
  output logic      [15:0] word_r
);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      word_r <= anps_pkg::PA_RESET;
    end else if (load) begin
      word_r <= word_in;
    end
  end

  a_word_loads: assert property (
    @(posedge mclk) disable iff (!arst_n)
    load |=> word_r == $past(word_in))
    else $error("page word not captured");

endmodule // page_word_hold

// *** rtl/page_rx_flag.sv ***
// Sticky page-received flag, cleared when software reads it.
// Assumes set and read strobes are single-cycle and synchronous.
`timescale 1ns/1ps
module page_rx_flag (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic set_pulse,
  input  wire logic rd_clear,
  output logic      flag_r
);

  // A set in the same cycle as the clearing read wins, so no page is lost.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flag_r <= 1'b0;
    end else if (set_pulse) begin
      flag_r <= 1'b1;
    end else if (rd_clear) begin
      flag_r <= 1'b0;
    end
  end

  a_set_wins: assert property (
    @(posedge mclk) disable iff (!arst_n)
    set_pulse |=> flag_r)
    else $error("page event lost");

  a_read_clears: assert property (
    @(posedge mclk) disable iff (!arst_n)
    rd_clear && !set_pulse |=> !flag_r)
    else $error("flag not cleared by read");

endmodule // page_rx_flag

// *** rtl/autoneg_partner_page_status.sv ***
// Partner next-page ability and negotiation expansion status registers.
// Assumes the negotiation logic supplies status levels and a page strobe
// in the mclk domain, and management reads arrive as a one-cycle strobe.
`timescale 1ns/1ps
module autoneg_partner_page_status (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Management access.
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata_r,
  output logic             reg_hit,
  // Negotiation logic.
  input  wire logic        page_strobe,
  input  wire logic [15:0] page_word,
  input  wire logic        partner_ack,
  input  wire logic        parallel_detect_fault,
  input  wire logic        partner_pages_capable,
  input  wire logic        partner_negotiation_capable
);

  // ---------------------------------------------------------------
  // Received page and status
  // ---------------------------------------------------------------
  logic [15:0] page_word_r;
  logic        page_rx_r;
  logic        fault_r;
  logic        partner_pages_r;
  logic        partner_an_r;
  logic        ack_r;
  logic        rd_exp;
  logic        rd_pa;
  logic        wr_exp;
  logic [15:0] ability_view;
  logic [15:0] expansion_view;

  page_word_hold u_word (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .load    (page_strobe),
    .word_in (page_word),
    .word_r  (page_word_r)
  );

  assign rd_exp = reg_rd && (reg_addr == anps_pkg::EXPANSION_ADDR);
  assign rd_pa  = reg_rd && (reg_addr == anps_pkg::PARTNER_ABILITY_ADDR);
  assign wr_exp = reg_wr && (reg_addr == anps_pkg::EXPANSION_ADDR);

  page_rx_flag u_flag (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .set_pulse (page_strobe),
    .rd_clear  (rd_exp),
    .flag_r    (page_rx_r)
  );

  // Status levels are registered so a read never sees a mid-cycle change.
  // The cost is one cycle of lag between a level and what a read returns.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= parallel_detect_fault;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      partner_pages_r <= 1'b0;
    end else begin
      partner_pages_r <= partner_pages_capable;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      partner_an_r <= 1'b0;
    end else begin
      partner_an_r <= partner_negotiation_capable;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= partner_ack;
    end
  end

  // ---------------------------------------------------------------
  // Register views
  // ---------------------------------------------------------------
  always_comb begin
    ability_view = page_word_r;
    ability_view[anps_pkg::PA_ACK_BIT] = ack_r;
    expansion_view = 16'h0000;
    expansion_view[anps_pkg::EX_FAULT_BIT]         = fault_r;
    expansion_view[anps_pkg::EX_PARTNER_PAGES_BIT] = partner_pages_r;
    expansion_view[anps_pkg::EX_LOCAL_PAGES_BIT]   =
      anps_pkg::EX_LOCAL_PAGES_RESET;
    expansion_view[anps_pkg::EX_PAGE_RX_BIT]       = page_rx_r;
    expansion_view[anps_pkg::EX_PARTNER_AN_BIT]    = partner_an_r;
  end

  assign reg_hit = (reg_addr == anps_pkg::PARTNER_ABILITY_ADDR) ||
                   (reg_addr == anps_pkg::EXPANSION_ADDR);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Writes are accepted and dropped: every bit here is read-only.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        anps_pkg::PARTNER_ABILITY_ADDR: reg_rdata_r <= ability_view;
        anps_pkg::EXPANSION_ADDR:       reg_rdata_r <= expansion_view;
        default:                        reg_rdata_r <= 16'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Every read check looks one edge past the read strobe, where the read data
  // has settled. Status levels pass one flop before the read flop, so
  // their expected value is the one seen two edges earlier.

  // A page lands at one edge and the partner register is read at the
  // next one; the read data then carries the fields of that page.
  sequence s_page_then_pa_read;
    page_strobe ##1 (rd_pa && !page_strobe);
  endsequence

  // A page lands, two edges pass without an expansion read, then one comes.
  sequence s_page_then_late_exp_read;
    page_strobe ##1 (!rd_exp) [*2] ##1 rd_exp;
  endsequence

  // Two expansion reads two edges apart with no page in between.
  sequence s_exp_read_twice;
    (rd_exp && !page_strobe) ##1 !page_strobe ##1 rd_exp;
  endsequence

  // A page and an expansion read meet in one cycle, and the next
  // expansion read follows two edges later.
  sequence s_clash_then_exp_read;
    (rd_exp && page_strobe) ##1 !rd_exp ##1 rd_exp;
  endsequence

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Read data moves only on a read; a write alone never touches it.
  a_rdata_holds: assert property (
    @(posedge mclk) disable iff (!arst_n)
    !reg_rd |=> $stable(reg_rdata_r))
    else $error("read data moved without a read");

  a_write_ignored: assert property (
    @(posedge mclk) disable iff (!arst_n)
    reg_wr && !reg_rd |=> $stable(reg_rdata_r))
    else $error("write changed read data");

  a_unmapped_zero: assert property (
    @(posedge mclk) disable iff (!arst_n)
    reg_rd && !reg_hit |=> reg_rdata_r == 16'h0000)
    else $error("unmapped read not zero");

  // ---------------------------------------------------------------
  // Expansion register
  // ---------------------------------------------------------------
  // Reserved expansion bits read as zero, checked bit by bit.
  genvar b;
  generate
    for (b = anps_pkg::EX_FAULT_BIT + 1; b < 16; b = b + 1) begin : g_res
      a_reserved_bit: assert property (
        @(posedge mclk) disable iff (!arst_n)
        rd_exp |=> !reg_rdata_r[b])
        else $error("reserved expansion bit set");
    end
  endgenerate

  a_reserved_zero: assert property (
    @(posedge mclk) disable iff (!arst_n)
    rd_exp |=> (reg_rdata_r & anps_pkg::EX_RESERVED_MASK) == 16'h0000)
    else $error("reserved expansion bits nonzero");

  a_local_pages_one: assert property (
    @(posedge mclk) disable iff (!arst_n)
    rd_exp |=> reg_rdata_r[anps_pkg::EX_LOCAL_PAGES_BIT])
    else $error("local pages bit not one");

  // Writing a zero over the local bit must not take it away.
  a_local_not_writable: assert property (
    @(posedge mclk) disable iff (!arst_n)
    wr_exp && !reg_wdata[anps_pkg::EX_LOCAL_PAGES_BIT] |=>
      expansion_view[anps_pkg::EX_LOCAL_PAGES_BIT])
    else $error("local pages bit cleared by write");

  a_fault_shown: assert property (
    @(posedge mclk) disable iff (!arst_n)
    rd_exp |=> reg_rdata_r[anps_pkg::EX_FAULT_BIT] ==
      $past(parallel_detect_fault, 2))
    else $error("fault not reported");

  a_partner_np: assert property (
    @(posedge mclk) disable iff (!arst_n)
    rd_exp |=> reg_rdata_r[anps_pkg::EX_PARTNER_PAGES_BIT] ==
      $past(partner_pages_capable, 2))
    else $error("partner pages bit wrong");

  a_partner_an: assert property (
    @(posedge mclk) disable iff (!arst_n)
    rd_exp |=> reg_rdata_r[anps_pkg::EX_PARTNER_AN_BIT] ==
      $past(partner_negotiation_capable, 2))
    else $error("partner negotiation bit wrong");

  a_page_rx_seen: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_page_then_late_exp_read |=> reg_rdata_r[anps_pkg::EX_PAGE_RX_BIT])
    else $error("page receipt not reported");

  a_page_rx_cleared: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_exp_read_twice |=> !reg_rdata_r[anps_pkg::EX_PAGE_RX_BIT])
    else $error("page flag not cleared by read");

  // Without a read the flag stays set until software looks at it.
  a_page_rx_holds: assert property (
    @(posedge mclk) disable iff (!arst_n)
    page_rx_r && !rd_exp |=> page_rx_r)
    else $error("page flag dropped without a read");

  a_page_rx_kept: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_clash_then_exp_read |=> reg_rdata_r[anps_pkg::EX_PAGE_RX_BIT])
    else $error("page lost under a clearing read");

  // ---------------------------------------------------------------
  // Partner ability register
  // ---------------------------------------------------------------
  // The acknowledge comes from its own input, never from the page word.
  a_ack_shown: assert property (
    @(posedge mclk) disable iff (!arst_n)
    rd_pa |=> reg_rdata_r[anps_pkg::PA_ACK_BIT] ==
      $past(partner_ack, 2))
    else $error("acknowledge not reported");

  // The held page word moves only when a page lands.
  a_word_held: assert property (
    @(posedge mclk) disable iff (!arst_n)
    !page_strobe |=> $stable(page_word_r))
    else $error("page word moved without a page");

  // Each field of a landed page is checked on its own, so a swapped
  // pair of bits shows up by name.
  a_more_pages: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_page_then_pa_read |=> reg_rdata_r[anps_pkg::PA_MORE_PAGES_BIT] ==
      $past(page_word[anps_pkg::PA_MORE_PAGES_BIT], 2))
    else $error("more pages bit not reported");

  a_page_fields: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_page_then_pa_read |=> reg_rdata_r[anps_pkg::PA_PAGE_TYPE_BIT] ==
      $past(page_word[anps_pkg::PA_PAGE_TYPE_BIT], 2))
    else $error("page type not reported");

  a_comply_bit: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_page_then_pa_read |=> reg_rdata_r[anps_pkg::PA_COMPLY_BIT] ==
      $past(page_word[anps_pkg::PA_COMPLY_BIT], 2))
    else $error("comply bit not reported");

  a_toggle_bit: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_page_then_pa_read |=> reg_rdata_r[anps_pkg::PA_TOGGLE_BIT] ==
      $past(page_word[anps_pkg::PA_TOGGLE_BIT], 2))
    else $error("toggle not reported");

  a_code_field: assert property (
    @(posedge mclk) disable iff (!arst_n)
    s_page_then_pa_read |=> reg_rdata_r[anps_pkg::PA_CODE_MSB:0] ==
      $past(page_word[anps_pkg::PA_CODE_MSB:0], 2))
    else $error("page code not reported");

endmodule // autoneg_partner_page_status

// *** test/neg_partner.sv ***
// Behavioural stand-in for the negotiation logic that hands over pages.
// Assumes the bench calls send just after a rising edge of mclk.
`timescale 1ns/1ps
module neg_partner (
  input  wire logic        mclk,
  output logic             page_strobe,
  output logic      [15:0] page_word
);
  initial begin
    page_strobe = 1'b0;
    page_word   = 16'hA5A5;
  end

  // The word is inverted once the strobe drops, so that a design which
  // samples it late picks up wrong data instead of a lucky match.
  task automatic send(input logic [15:0] w);
    page_word   = w;
    page_strobe = 1'b1;
    @(posedge mclk);
    #1;
    page_strobe = 1'b0;
    page_word   = ~w;
  endtask
endmodule // neg_partner

// *** test/tb_top.sv ***
// Self-checking bench for the partner page and expansion status registers.
// Assumes the design and its package are compiled before this file.
`timescale 1ns/1ps
module tb_top;
  logic        mclk      = 1'b0;
  logic        arst_n    = 1'b0;
  logic [4:0]  reg_addr  = 5'h00;
  logic        reg_rd    = 1'b0;
  logic        reg_wr    = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata_r;
  logic        reg_hit;
  logic        page_strobe;
  logic [15:0] page_word;
  logic        ack       = 1'b0;
  logic        fault     = 1'b0;
  logic        ppg       = 1'b0;
  logic        pan       = 1'b0;
  logic [15:0] word_m    = 16'h0000;
  int          flag      = 0;
  int          bad_count = 0;
  int          checks    = 0;

  always #5 mclk = ~mclk;

  neg_partner u_partner (.mclk(mclk), .page_strobe(page_strobe),
                         .page_word(page_word));

  autoneg_partner_page_status u_dut (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .reg_hit(reg_hit), .page_strobe(page_strobe), .page_word(page_word),
    .partner_ack(ack), .parallel_detect_fault(fault),
    .partner_pages_capable(ppg), .partner_negotiation_capable(pan));

  // ---------------------------------------------------------------
  // Reference model and bus tasks
  // ---------------------------------------------------------------
  function automatic logic [15:0] pa_exp();
    return {word_m[15], ack, word_m[13:0]};
  endfunction

  function automatic logic [15:0] ex_exp();
    return {11'h000, fault, ppg, 1'b1, flag[0], pan};
  endfunction

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    reg_addr = a;
    reg_rd   = 1'b1;
    tick();
    reg_rd = 1'b0;
    tick();
    cmp(reg_rdata_r, exp);
    cmp({15'h0000, reg_hit}, {15'h0000, (a == 5'h05) || (a == 5'h06)});
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask

  task automatic wrap_up();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #100us;
    bad_count++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h5823A81E));
    repeat (12) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    tick();
    rd(5'h05, 16'h0000);
    rd(5'h06, ex_exp());
    for (int i = 0; i < 12; i++) begin
      {ack, fault, ppg, pan} = 4'($urandom);
      word_m = 16'($urandom);
      u_partner.send(word_m);
      flag = 1;
      rd(5'h05, pa_exp());
      rd(5'h06, ex_exp());
      flag = 0;
      rd(5'h06, ex_exp());
    end
    // Software leaves the partner ability register alone; only 06h is written.
    wr(5'h06, 16'hFFFF);
    wr(5'h06, 16'($urandom));
    wr(5'h06, 16'h0000);
    rd(5'h06, ex_exp());
    rd(5'h05, pa_exp());
    word_m = 16'($urandom);
    fork
      rd(5'h06, ex_exp());
      u_partner.send(word_m);
    join
    flag = 1;
    rd(5'h06, ex_exp());
    flag = 0;
    rd(5'h05, pa_exp());
    rd(5'h1F, 16'h0000);
    // A second reset in mid-run: only levels and the local bit survive it.
    arst_n = 1'b0;
    tick();
    cmp(reg_rdata_r, 16'h0000);
    arst_n = 1'b1;
    word_m = 16'h0000;
    flag   = 0;
    tick();
    rd(5'h05, pa_exp());
    rd(5'h06, ex_exp());
    wrap_up();
  end
endmodule // tb_top
